// ==== bench/uol_flash_model.sv ====
// information block model: answers each fetch after a chosen lag
`timescale 1ns/1ps
module uol_flash_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        fl_rd,
  input wire logic [31:0] fl_addr,
  input wire logic [95:0] words,
  input wire logic [1:0]  lag,
  output logic            fl_rvalid,
  output logic     [31:0] fl_rdata
);
  logic       busy;
  logic [1:0] cnt;
  // data toggles when not valid so a stale word is never mistaken for fresh
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0; cnt <= 2'h0; fl_rvalid <= 1'b0; fl_rdata <= 32'h5a5a_5a5a;
    end else begin
      fl_rvalid <= 1'b0;
      fl_rdata <= ~fl_rdata;
      if (fl_rd) begin
        busy <= 1'b1; cnt <= lag;
      end else if (busy && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0; fl_rvalid <= 1'b1;
        fl_rdata <= words[{fl_addr[3:2], 5'h0} +: 32];
      end
    end
  end
endmodule

// ==== bench/uol_loader_asserts.sv ====
// protocol and load checks on the option loader ports
`timescale 1ns/1ps
module uol_loader_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        fl_rd,
  input wire logic [31:0] fl_addr,
  input wire logic        fl_rvalid,
  input wire logic        flash_ready,
  input wire logic        probe_main,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        option_load_error_flag,
  input wire logic [1:0]  access_protect_level,
  input wire logic        sram_parity_disable,
  input wire logic        standby_watchdog_run,
  input wire logic        deepsleep_watchdog_run,
  input wire logic        standby_no_reset,
  input wire logic        deepsleep_no_reset,
  input wire logic        watchdog_autostart_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fetch side
  a_rd_pulse: assert property (fl_rd |=> !fl_rd) else $error("fetch strobe too long");
  a_fetch_area: assert property (fl_rd |-> fl_addr inside {32'h1fff_f800, 32'h1fff_f804,
    32'h1fff_f808}) else $error("fetch outside option area");
  a_next_fetch: assert property (fl_rvalid && fl_addr == 32'h1fff_f800 && !flash_ready
    |=> ##1 fl_rd && fl_addr == 32'h1fff_f804) else $error("second word not fetched");
  a_ready_hold: assert property (flash_ready |=> flash_ready) else $error("ready dropped");
  a_no_early: assert property (probe_main |-> flash_ready) else $error("main access early");
  a_err_sticky: assert property (option_load_error_flag |=> option_load_error_flag)
    else $error("error flag lost");
  // register bus, one wait state then one answer cycle
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer late");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer stuck");
  a_unmapped: assert property (avs_read && avs_waitrequest && avs_address == 4'hc
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_flag_read: assert property (avs_read && avs_waitrequest && avs_address == 4'h0
    && $past(flash_ready) |=> avs_readdata[0] == option_load_error_flag
    && avs_readdata[1] == (access_protect_level != 2'h0)) else $error("flag copy wrong");
  a_setting_copy: assert property (avs_read && avs_waitrequest && avs_address == 4'h0
    && $past(flash_ready) |=> avs_readdata[9:7] == {sram_parity_disable,
    standby_watchdog_run, deepsleep_watchdog_run} && avs_readdata[4:2] ==
    {standby_no_reset, deepsleep_no_reset, watchdog_autostart_off}) else $error("setting copy");
endmodule

// ==== bench/uol_loader_tb.sv ====
// self-checking bench for the option loader
`timescale 1ns/1ps
module uol_loader_tb;
  logic clk = 0, rst_n = 0, boot_pin = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, probe_addr = 32'h0, q, q0;
  logic [95:0] words = 96'h0;
  logic [1:0] lag = 2'h0, lvl, access_protect_level;
  logic fl_rd, fl_rvalid, flash_ready, probe_main, probe_protected, probe_boot, probe_usd;
  logic sram_parity_disable, standby_watchdog_run, deepsleep_watchdog_run, boot_from_sram;
  logic standby_no_reset, deepsleep_no_reset, watchdog_autostart_off, option_load_error_flag;
  logic [31:0] fl_addr, fl_rdata, avs_readdata;
  logic avs_waitrequest, err;
  logic [6:0] probe_sector, s, sector2;
  logic fl_rd2, fl_rvalid2, protected2;
  logic [31:0] fl_addr2, fl_rdata2;
  logic [7:0] ev[6];
  logic [15:0] p, ep;
  int num_errors = 0, compares = 0, m;
  always #50 clk = ~clk;
  uol_loader dut (.clk(clk), .rst_n(rst_n), .fl_rd(fl_rd), .fl_addr(fl_addr),
    .fl_rvalid(fl_rvalid), .fl_rdata(fl_rdata), .flash_ready(flash_ready),
    .probe_addr(probe_addr), .probe_main(probe_main), .probe_sector(probe_sector),
    .probe_protected(probe_protected), .probe_boot(probe_boot), .probe_usd(probe_usd),
    .boot_pin(boot_pin), .access_protect_level(access_protect_level),
    .sram_parity_disable(sram_parity_disable), .standby_watchdog_run(standby_watchdog_run),
    .deepsleep_watchdog_run(deepsleep_watchdog_run), .boot_from_sram(boot_from_sram),
    .standby_no_reset(standby_no_reset), .deepsleep_no_reset(deepsleep_no_reset),
    .watchdog_autostart_off(watchdog_autostart_off),
    .option_load_error_flag(option_load_error_flag), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  uol_flash_model u_fl (.clk(clk), .rst_n(rst_n), .fl_rd(fl_rd), .fl_addr(fl_addr),
    .words(words), .lag(lag), .fl_rvalid(fl_rvalid), .fl_rdata(fl_rdata));
  // small array variant, only its probe decode is compared
  uol_loader #(.BIG_ARRAY(1'b0)) dut_small (.clk(clk), .rst_n(rst_n), .fl_rd(fl_rd2),
    .fl_addr(fl_addr2), .fl_rvalid(fl_rvalid2), .fl_rdata(fl_rdata2), .flash_ready(),
    .probe_addr(probe_addr), .probe_main(), .probe_sector(sector2),
    .probe_protected(protected2), .probe_boot(), .probe_usd(), .boot_pin(boot_pin),
    .access_protect_level(), .sram_parity_disable(), .standby_watchdog_run(),
    .deepsleep_watchdog_run(), .boot_from_sram(), .standby_no_reset(),
    .deepsleep_no_reset(), .watchdog_autostart_off(), .option_load_error_flag(),
    .avs_address(4'h0), .avs_read(1'b0), .avs_write(1'b0), .avs_writedata(32'h0),
    .avs_byteenable(4'hf), .avs_readdata(), .avs_waitrequest());
  uol_flash_model u_fl2 (.clk(clk), .rst_n(rst_n), .fl_rd(fl_rd2), .fl_addr(fl_addr2),
    .words(words), .lag(lag), .fl_rvalid(fl_rvalid2), .fl_rdata(fl_rdata2));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  // waitrequest and data are looked at mid-cycle, settled, for the edge that follows
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic w;
    n = 0;
    @(posedge clk);
    avs_read <= !wr; avs_write <= wr; avs_address <= a; avs_writedata <= d;
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      n++;
    end while (w !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, w});
    avs_read <= 1'b0; avs_write <= 1'b0;
  endtask
  task automatic end_sim();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(15031));
    for (int t = 0; t < 10; t++) begin
      // random pairs: some good, some broken, some erased
      err = 1'b0;
      for (int i = 0; i < 6; i++) begin
        m = $urandom % 8; ev[i] = $urandom;
        if (i == 0 && t < 2) ev[0] = t ? 8'hcc : 8'ha5;
        p = (m == 7) ? 16'hffff : {~ev[i] ^ ((m == 6) ? 8'h01 : 8'h00), ev[i]};
        words[16 * i +: 16] = p;
        if (p != 16'hffff && p[15:8] != ~p[7:0]) begin
          ev[i] = 8'hff; err = 1'b1;
        end else ev[i] = p[7:0];
      end
      lvl = (ev[0] == 8'ha5) ? 2'h0 : (ev[0] == 8'hcc) ? 2'h2 : 2'h1;
      ep = {ev[5], ev[4]};
      boot_pin <= $urandom; lag <= $urandom;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      m = 0;
      while (flash_ready !== 1'b1 && m < 100) begin
        @(posedge clk);
        m++;
      end
      repeat (5) @(posedge clk);
      chk("ready", 32'h1, {31'h0, flash_ready});
      bus(1'b0, 4'h0, 32'h0); q0 = q;
      chk("usd", {6'h0, ev[3], ev[2], ev[1], lvl != 2'h0, err}, q & 32'h03ff_ffff);
      bus(1'b0, 4'h4, 32'h0);
      chk("epps", {16'h0, ep}, q & 32'h0000_ffff);
      bus(1'b0, 4'h8, 32'h0);
      chk("status", {28'h0, lvl, 1'b1, err}, q & 32'h0000_000f);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped", 32'h0, q);
      chk("level", {30'h0, lvl}, {30'h0, access_protect_level});
      chk("setting", {26'h0, ev[1][7:5], ev[1][2:0]}, {26'h0, sram_parity_disable,
        standby_watchdog_run, deepsleep_watchdog_run, standby_no_reset,
        deepsleep_no_reset, watchdog_autostart_off});
      chk("boot", {31'h0, boot_pin & ~ev[1][4]}, {31'h0, boot_from_sram});
      chk("errflag", {31'h0, err}, {31'h0, option_load_error_flag});
      s = $urandom;
      probe_addr <= 32'h0800_0000 + ({25'h0, s} << 11);
      repeat (2) @(posedge clk);
      chk("sector", {25'h0, s}, {25'h0, probe_sector});
      chk("protect", {31'h0, s < 7'd32 && !ep[s[4:1]]}, {31'h0, probe_protected});
      chk("main", 32'h1, {31'h0, probe_main});
      chk("sector small", {25'h0, s[5:0], 1'b0}, {25'h0, sector2});
      chk("protect small", {31'h0, s < 7'd32 && !ep[s[4:1]]}, {31'h0, protected2});
      probe_addr <= (t % 2) ? 32'h1fff_a400 : 32'h1fff_f9fc;
      repeat (2) @(posedge clk);
      chk("region", {30'h0, t[0], ~t[0]}, {30'h0, probe_boot, probe_usd});
      // flash and bus changes must not reach loaded values before a reset
      words = ~words;
      bus(1'b1, 4'h0, $urandom);
      bus(1'b0, 4'h0, 32'h0);
      chk("reload", q0, q);
    end
    end_sim();
  end
endmodule
bind uol_loader uol_loader_asserts u_chk (.*);

// ==== hw/uol_loader.sv ====
// user option loader: reset-time fetch of option words into registers
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module uol_loader #(
  parameter bit BIG_ARRAY = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // flash information block read port
  output logic             fl_rd,
  output logic      [31:0] fl_addr,
  input  wire logic        fl_rvalid,
  input  wire logic [31:0] fl_rdata,
  // main array access gating
  output logic             flash_ready,
  input  wire logic [31:0] probe_addr,
  output logic             probe_main,
  output logic      [6:0]  probe_sector,
  output logic             probe_protected,
  output logic             probe_boot,
  output logic             probe_usd,
  // boot pin, asynchronous
  input  wire logic        boot_pin,
  // decoded options
  output logic      [1:0]  access_protect_level,
  output logic             sram_parity_disable,
  output logic             standby_watchdog_run,
  output logic             deepsleep_watchdog_run,
  output logic             boot_from_sram,
  output logic             standby_no_reset,
  output logic             deepsleep_no_reset,
  output logic             watchdog_autostart_off,
  output logic             option_load_error_flag,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  typedef enum logic [1:0] {UOL_FETCH, UOL_WAIT, UOL_DONE} uol_state_e;

  typedef struct packed {
    uol_state_e  state;
    logic [1:0]  word_idx;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] usd;
    logic [31:0] epps;
    logic        err;
    logic        ready;
    logic [2:0]  boot_sync;
    logic        boot_lvl;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  ap;
    logic [7:0]  flags;
    logic        p_main;
    logic [6:0]  p_sector;
    logic        p_prot;
    logic        p_boot;
    logic        p_usd;
  } uol_state_s;

  uol_state_s cur;
  uol_state_s nxt;

  logic [7:0] val_lo;
  logic [7:0] val_hi;
  logic       bad_lo;
  logic       bad_hi;
  logic       d_main;
  logic [6:0] d_sector;
  logic       d_boot;
  logic       d_usd;
  logic [3:0] prot_bit;

  // each option word carries two pairs
  uol_pair_check u_pair_lo (
    .pair_in (fl_rdata[15:0]),
    .value   (val_lo),
    .bad     (bad_lo)
  );

  uol_pair_check u_pair_hi (
    .pair_in (fl_rdata[31:16]),
    .value   (val_hi),
    .bad     (bad_hi)
  );

  uol_sector_decode u_dec (
    .addr      (probe_addr),
    .big_array (BIG_ARRAY),
    .in_main   (d_main),
    .sector    (d_sector),
    .in_boot   (d_boot),
    .in_usd    (d_usd)
  );

  // next state
  always_comb begin
    nxt = cur;
    nxt.rd  = 1'b0;
    nxt.ack = 1'b0;
    // boot pin: three flops, change taken once the last two agree
    nxt.boot_sync = {cur.boot_sync[1:0], boot_pin};
    if (cur.boot_sync[2] == cur.boot_sync[1]) begin
      nxt.boot_lvl = cur.boot_sync[2];
    end

    // loader runs once after each reset, then sits in done until next reset
    case (cur.state)
      UOL_FETCH: begin
        nxt.rd    = 1'b1;
        nxt.addr  = uol_pkg::USD_BASE + {28'h0000000, cur.word_idx, 2'b00};
        nxt.state = UOL_WAIT;
      end
      UOL_WAIT: begin
        if (fl_rvalid) begin
          if (bad_lo || bad_hi) begin
            nxt.err = 1'b1;
          end
          case (cur.word_idx)
            2'd0: begin
              // access byte decoded after the complement check; a broken pair decodes as the erased byte
              nxt.usd[uol_pkg::USD_AP_BIT] = (val_lo != uol_pkg::AP_NONE_CODE);
              if (val_lo == uol_pkg::AP_NONE_CODE) begin
                nxt.ap = 2'(uol_pkg::UOL_AP_NONE);
              end else if (val_lo == uol_pkg::AP_HIGH_CODE) begin
                nxt.ap = 2'(uol_pkg::UOL_AP_HIGH);
              end else begin
                nxt.ap = 2'(uol_pkg::UOL_AP_LOW);
              end
              nxt.usd[uol_pkg::USD_SSB_LSB +: 8] = val_hi;
            end
            2'd1: begin
              nxt.usd[uol_pkg::USD_UB0_LSB +: 8] = val_lo;
              nxt.usd[uol_pkg::USD_UB1_LSB +: 8] = val_hi;
            end
            default: begin
              nxt.epps[7:0]  = val_lo;
              nxt.epps[15:8] = val_hi;
            end
          endcase
          if (cur.word_idx == 2'(uol_pkg::NUM_OPT_WORDS - 1)) begin
            nxt.state = UOL_DONE;
          end else begin
            nxt.word_idx = cur.word_idx + 2'd1;
            nxt.state    = UOL_FETCH;
          end
        end
      end
      UOL_DONE: begin
        nxt.ready = 1'b1;
      end
      default: begin
        nxt.state = UOL_FETCH;
      end
    endcase
    nxt.usd[uol_pkg::USD_ERR_BIT] = nxt.err;

    // options decoded from the setting byte image
    nxt.flags[0] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_PARITY_DIS];
    nxt.flags[1] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_SBY_WDT];
    nxt.flags[2] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_DSL_WDT];
    // boot memory only when pin high and option bit low
    nxt.flags[3] = cur.boot_lvl &&
                   !cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_BOOT_SEL];
    nxt.flags[4] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_SBY_NORST];
    nxt.flags[5] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_DSL_NORST];
    nxt.flags[6] = cur.usd[uol_pkg::USD_SSB_LSB + uol_pkg::SSB_WDT_OFF];
    nxt.flags[7] = 1'b0;

    // probe decode; only the main hit is gated until the options are valid
    // one bit per 4 KB: two large sectors or four small ones
    prot_bit = BIG_ARRAY ? d_sector[4:1] : d_sector[5:2];
    nxt.p_main   = d_main && cur.ready;
    nxt.p_sector = d_sector;
    nxt.p_prot   = d_main && (d_sector < (BIG_ARRAY ? 7'd32 : 7'd64)) &&
                   !cur.epps[prot_bit];
    nxt.p_boot   = d_boot;
    nxt.p_usd    = d_usd;

    // avalon slave: one wait cycle, then answer; registers are read-only
    if ((avs_read || avs_write) && !cur.ack) begin
      nxt.ack = 1'b1;
      case (avs_address)
        uol_pkg::OFS_USD:    nxt.rdata = cur.usd;
        uol_pkg::OFS_EPPS:   nxt.rdata = cur.epps;
        uol_pkg::OFS_STATUS: nxt.rdata = {28'h0000000, cur.ap, cur.ready, cur.err};
        default:             nxt.rdata = uol_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  // single state register; the image only changes during the post-reset load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur       <= '0;
      cur.state <= UOL_FETCH;
      cur.usd   <= uol_pkg::USD_RESET;
      cur.epps  <= uol_pkg::EPPS_RESET;
    end else begin
      cur <= nxt;
    end
  end

  // outputs straight from flops
  assign fl_rd                  = cur.rd;
  assign fl_addr                = cur.addr;
  assign flash_ready            = cur.ready;
  assign probe_main             = cur.p_main;
  assign probe_sector           = cur.p_sector;
  assign probe_protected        = cur.p_prot;
  assign probe_boot             = cur.p_boot;
  assign probe_usd              = cur.p_usd;
  assign access_protect_level   = cur.ap;
  assign sram_parity_disable    = cur.flags[0];
  assign standby_watchdog_run   = cur.flags[1];
  assign deepsleep_watchdog_run = cur.flags[2];
  assign boot_from_sram         = cur.flags[3];
  assign standby_no_reset       = cur.flags[4];
  assign deepsleep_no_reset     = cur.flags[5];
  assign watchdog_autostart_off = cur.flags[6];
  assign option_load_error_flag = cur.err;
  assign avs_readdata           = cur.rdata;
  // waitrequest high until the registered answer is ready
  assign avs_waitrequest        = !cur.ack;

endmodule

// ==== hw/uol_pair_check.sv ====
// one option pair: complement check and forcing to erased value
`timescale 1ns/1ps
module uol_pair_check (
  input  wire logic [15:0] pair_in,
  output logic      [7:0]  value,
  output logic             bad
);
  // mismatch unless complement holds or pair is still erased
  always_comb begin
    bad   = (pair_in[15:8] != ~pair_in[7:0]) && (pair_in != uol_pkg::ERASED_PAIR);
    value = bad ? uol_pkg::ERASED_BYTE : pair_in[7:0];
  end
endmodule

// ==== hw/uol_sector_decode.sv ====
// main array sector index decode for the two array sizes
`timescale 1ns/1ps
module uol_sector_decode (
  input  wire logic [31:0] addr,
  input  wire logic        big_array,
  output logic             in_main,
  output logic      [6:0]  sector,
  output logic             in_boot,
  output logic             in_usd
);
  logic [31:0] ofs;
  logic [31:0] idx;
  // sector size 2 KB on the large array, 1 KB on the small one
  always_comb begin
    ofs = addr - uol_pkg::MAIN_BASE;
    idx = big_array ? (ofs >> uol_pkg::SECT_SH_256K) : (ofs >> uol_pkg::SECT_SH_128K);
    in_main = (addr >= uol_pkg::MAIN_BASE) && (idx < 32'(uol_pkg::NUM_SECTORS));
    sector  = idx[6:0];
    in_boot = (addr >= uol_pkg::BOOT_BASE) && (addr <= uol_pkg::BOOT_LAST);
    in_usd  = (addr >= uol_pkg::USD_BASE) && (addr <= uol_pkg::USD_LAST);
  end
endmodule

// ==== shared/uol_pkg.sv ====
// constants and types shared by the user option loader
package uol_pkg;

  // information block and main array map
  localparam logic [31:0] USD_BASE      = 32'h1fff_f800;
  localparam logic [31:0] USD_LAST      = 32'h1fff_f9ff;
  localparam logic [31:0] BOOT_BASE     = 32'h1fff_a400;
  localparam logic [31:0] BOOT_LAST     = 32'h1fff_f3ff;
  localparam logic [31:0] MAIN_BASE     = 32'h0800_0000;
  localparam int          NUM_SECTORS   = 128;
  localparam int          SECT_SH_256K  = 11;
  localparam int          SECT_SH_128K  = 10;
  localparam logic [31:0] OPT_WORD_STEP = 32'h0000_0004;
  localparam int          NUM_OPT_WORDS = 3;

  // pair checking
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [15:0] ERASED_PAIR   = 16'hffff;

  // access protection decode
  localparam logic [7:0]  AP_NONE_CODE  = 8'ha5;
  localparam logic [7:0]  AP_HIGH_CODE  = 8'hcc;
  typedef enum logic [1:0] {UOL_AP_NONE, UOL_AP_LOW, UOL_AP_HIGH} uol_ap_e;

  // setting byte bits
  localparam int SSB_PARITY_DIS = 7;
  localparam int SSB_SBY_WDT    = 6;
  localparam int SSB_DSL_WDT    = 5;
  localparam int SSB_BOOT_SEL   = 4;
  localparam int SSB_SBY_NORST  = 2;
  localparam int SSB_DSL_NORST  = 1;
  localparam int SSB_WDT_OFF    = 0;

  // loaded option register layout
  localparam int USD_ERR_BIT   = 0;
  localparam int USD_AP_BIT    = 1;
  localparam int USD_SSB_LSB   = 2;
  localparam int USD_UB0_LSB   = 10;
  localparam int USD_UB1_LSB   = 18;
  localparam logic [31:0] USD_RESET  = 32'h0000_0000;
  localparam logic [31:0] EPPS_RESET = 32'h0000_0000;

  // register bus map, word offsets in bytes
  localparam logic [3:0] OFS_USD    = 4'h0;
  localparam logic [3:0] OFS_EPPS   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // status register bits
  localparam int STS_ERR  = 0;
  localparam int STS_DONE = 1;
  localparam int STS_AP_LSB = 2;

endpackage
